/* File: design/ccsr_defs.vh */
// Purpose: shared constants for the charger control and status register bank
// Assumes: 10 MHz core clock, byte-wide registers behind a two-wire serial slave
// Notes:   offsets, masks, bit positions, reset values and timing counts
`ifndef CCSR_DEFS_VH
`define CCSR_DEFS_VH

// register offsets
`define CCSR_OFS_POWER_ON_CFG   8'h01
`define CCSR_OFS_TIMER_TERM     8'h05
`define CCSR_OFS_MISC_CTRL      8'h06
`define CCSR_OFS_SYS_STATE      8'h07
`define CCSR_OFS_FAULT          8'h08

// reset values and writable masks
`define CCSR_RST_TIMER_TERM     8'h4A
`define CCSR_MSK_TIMER_TERM     8'h7F
`define CCSR_RST_MISC_CTRL      8'h0B
`define CCSR_MSK_MISC_CTRL      8'h2B
`define CCSR_RST_SYS_STATE      8'h00
`define CCSR_RST_FAULT          8'h00

// power-on configuration command bits
`define CCSR_BIT_REG_RESET      7
`define CCSR_BIT_WDOG_KICK      6

// timer and termination control fields
`define CCSR_BIT_TERM_EN        6
`define CCSR_BIT_WDOG_HI        5
`define CCSR_BIT_WDOG_LO        4
`define CCSR_BIT_STMR_EN        3
`define CCSR_BIT_STMR_HI        2
`define CCSR_BIT_STMR_LO        1
`define CCSR_BIT_TERMINATION_TIMER_OPTION       0

// miscellaneous control fields
`define CCSR_BIT_BATT_OFF       5
`define CCSR_BIT_NTC_EN         3
`define CCSR_BIT_TJ_HI          1
`define CCSR_BIT_TJ_LO          0

// fault register bits
`define CCSR_BIT_F_WDOG         6
`define CCSR_BIT_F_INPUT        5
`define CCSR_BIT_F_TSD          4
`define CCSR_BIT_F_BATOV        3
`define CCSR_BIT_F_STMR         2

// watchdog period codes and times in seconds
`define CCSR_WDOG_OFF           2'h0
`define CCSR_WDOG_40S           2'h1
`define CCSR_WDOG_80S           2'h2
`define CCSR_WDOG_T1_S          8'h28
`define CCSR_WDOG_T2_S          8'h50
`define CCSR_WDOG_T3_S          8'hA0

// timing: one second expressed in core clock cycles
`define CCSR_CLK_PERIOD_NS      100
`define CCSR_SECOND_NS          1000000000
`define CCSR_SECOND_CYCLES      (`CCSR_SECOND_NS / `CCSR_CLK_PERIOD_NS)

`endif

/* File: design/ccsr_wdog.v */
// Purpose: host watchdog timer with one-second prescaler
// Assumes: i_kick is a one-cycle pulse on the core clock
// Notes:   expiry disarms the timer until the host kicks it again
`timescale 1ns/10ps
`default_nettype none
`include "ccsr_defs.vh"

module ccsr_wdog #(
  parameter [31:0] SECOND_CYCLES = `CCSR_SECOND_CYCLES  // cycles per second
) (
  input  wire       i_clock,   // core clock
  input  wire       i_arst_n,  // async reset, active low
  input  wire [1:0] i_period,  // watchdog period code
  input  wire       i_kick,    // host watchdog reset pulse
  input  wire       i_freeze,  // hold count, input supply absent
  output reg        o_expire   // one-cycle expiry pulse
);

  reg [31:0] presc_reg;
  reg [7:0]  sec_reg;
  reg        armed_reg;

  // period code to limit in seconds
  function [7:0] limit_of;
    input [1:0] code;
    begin
      case (code)
        `CCSR_WDOG_40S: limit_of = `CCSR_WDOG_T1_S;
        `CCSR_WDOG_80S: limit_of = `CCSR_WDOG_T2_S;
        default:        limit_of = `CCSR_WDOG_T3_S;
      endcase
    end
  endfunction

  // prescaler, second counter and arm state
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      presc_reg <= 32'h0;
      sec_reg   <= 8'h00;
      armed_reg <= 1'b1;
      o_expire  <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (i_kick || i_period == `CCSR_WDOG_OFF) begin
        presc_reg <= 32'h0;
        sec_reg   <= 8'h00;
        if (i_kick)
          armed_reg <= 1'b1;
      end else if (armed_reg && !i_freeze) begin
        if (presc_reg == SECOND_CYCLES - 32'h1) begin
          presc_reg <= 32'h0;
          if (sec_reg == limit_of(i_period) - 8'h01) begin
            sec_reg   <= 8'h00;
            armed_reg <= 1'b0;
            o_expire  <= 1'b1;
          end else begin
            sec_reg <= sec_reg + 8'h01;
          end
        end else begin
          presc_reg <= presc_reg + 32'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: design/ccsr_regs.v */
// Purpose: control and status register bank of a single-cell charger, serial slave
// Assumes: scl, sda and charger status inputs are asynchronous to i_clock
// Notes:   scl runs far slower than i_clock, so edges are found by sampling
`timescale 1ns/10ps
`default_nettype none
`include "ccsr_defs.vh"

module ccsr_regs #(
  parameter [6:0]  SLAVE_ADDR    = 7'h09,               // bus address, plain default
  parameter [1:0]  REVISION      = 2'h1,                // arbitrary revision code
  parameter [31:0] SECOND_CYCLES = `CCSR_SECOND_CYCLES  // watchdog prescale
) (
  input  wire       i_clock,                      // core clock, 10 MHz
  input  wire       i_arst_n,                     // async reset, active low
  input  wire       i_scl,                        // serial clock pin
  input  wire       i_sda,                        // serial data pin, input
  output wire       o_sda,                        // serial data pin, output level
  output reg        o_sda_oe,                     // serial data pin, drive enable
  input  wire [1:0] i_charge_state,               // charge state machine phase
  input  wire       i_path_limit_flag,            // power path limiting input
  input  wire       i_input_good_flag,            // input supply qualified good
  input  wire       i_thermal_regulation_flag,    // die thermal regulation active
  input  wire       i_input_fault_flag,           // input overvoltage or bad source
  input  wire       i_thermal_shutdown_flag,      // thermal shutdown event
  input  wire       i_battery_overvoltage_flag,   // battery overvoltage event
  input  wire       i_safety_timer_fault_flag,    // safety timer expired
  output wire       o_term_enable,                // charge termination enable
  output wire [1:0] o_host_watchdog_period,       // watchdog period code
  output wire       o_safety_timer_enable,        // safety timer enable
  output wire [1:0] o_safety_timer_duration,      // safety timer duration code
  output wire       o_termination_timer_option,   // termination timer option
  output wire       o_battery_switch_off,         // battery switch forced off
  output wire       o_thermistor_monitor_enable,  // thermistor monitoring enable
  output wire [1:0] o_junction_temp_limit,        // junction temperature limit code
  output reg        o_host_watchdog_expiry        // watchdog expired, one cycle
);

  // one-hot states of the serial slave
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_ADDR = 7'h02;
  localparam [6:0] S_AACK = 7'h04;
  localparam [6:0] S_RX   = 7'h08;
  localparam [6:0] S_WACK = 7'h10;
  localparam [6:0] S_TX   = 7'h20;
  localparam [6:0] S_MACK = 7'h40;

  reg  [1:0] scl_s1_reg;
  reg  [1:0] scl_s2_reg;
  reg        scl_d_reg;
  reg        sda_d_reg;
  reg  [8:0] stat_s1_reg;
  reg  [8:0] stat_s2_reg;
  reg  [6:0] state_reg;
  reg  [3:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg  [7:0] ptr_reg;
  reg        rw_reg;
  reg        first_reg;
  reg        nack_reg;
  reg        wr_en_reg;
  reg  [7:0] wr_addr_reg;
  reg  [7:0] wr_data_reg;
  reg        fault_clr_reg;
  reg  [7:0] timer_term_reg;
  reg  [7:0] misc_ctrl_reg;
  reg  [7:0] sys_state_reg;
  reg  [7:0] fault_reg;
  reg  [7:0] fault_next;
  wire       scl_now;
  wire       sda_now;
  wire       scl_rise;
  wire       scl_fall;
  wire       bus_start;
  wire       bus_stop;
  wire       reg_reset_cmd;
  wire       wdog_kick;
  wire       wdog_expire;
  wire       ctrl_default;
  wire [7:0] fault_set;
  wire [7:0] rd_byte;

  // read mux: unmapped offsets and command-only bits read zero
  function [7:0] read_byte;
    input [7:0] addr;
    input [7:0] tt;
    input [7:0] mc;
    input [7:0] ss;
    input [7:0] ff;
    begin
      case (addr)
        `CCSR_OFS_TIMER_TERM: read_byte = tt & `CCSR_MSK_TIMER_TERM;
        `CCSR_OFS_MISC_CTRL:  read_byte = mc & `CCSR_MSK_MISC_CTRL;
        `CCSR_OFS_SYS_STATE:  read_byte = ss;
        `CCSR_OFS_FAULT:      read_byte = ff;
        default:              read_byte = 8'h00;
      endcase
    end
  endfunction

  // byte presented to the host at the current pointer
  assign rd_byte = read_byte(ptr_reg, timer_term_reg, misc_ctrl_reg, sys_state_reg, fault_reg);

  // two-flop synchronisers for the bus pins
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      scl_s1_reg <= 2'h3;
      scl_s2_reg <= 2'h3;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
    end else begin
      scl_s1_reg <= {i_scl, i_sda};
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg[1];
      sda_d_reg  <= scl_s2_reg[0];
    end
  end

  assign scl_now   = scl_s2_reg[1];
  assign sda_now   = scl_s2_reg[0];
  assign scl_rise  = scl_now & ~scl_d_reg;
  assign scl_fall  = ~scl_now & scl_d_reg;
  assign bus_start = scl_now & scl_d_reg & sda_d_reg & ~sda_now;
  assign bus_stop  = scl_now & scl_d_reg & ~sda_d_reg & sda_now;
  assign o_sda     = 1'b0;  // open drain: only ever pulls low

  // two-flop synchronisers for charger status and fault levels
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_s1_reg <= 9'h000;
      stat_s2_reg <= 9'h000;
    end else begin
      stat_s1_reg <= {i_charge_state, i_path_limit_flag, i_input_good_flag,
                      i_thermal_regulation_flag, i_input_fault_flag,
                      i_thermal_shutdown_flag, i_battery_overvoltage_flag,
                      i_safety_timer_fault_flag};
      stat_s2_reg <= stat_s1_reg;
    end
  end

  // serial slave: address, register pointer, write data and read data
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg     <= S_IDLE;
      bit_cnt_reg   <= 4'h0;
      shift_reg     <= 8'h00;
      ptr_reg       <= 8'h00;
      rw_reg        <= 1'b0;
      first_reg     <= 1'b0;
      nack_reg      <= 1'b0;
      o_sda_oe      <= 1'b0;
      wr_en_reg     <= 1'b0;
      wr_addr_reg   <= 8'h00;
      wr_data_reg   <= 8'h00;
      fault_clr_reg <= 1'b0;
    end else begin
      wr_en_reg     <= 1'b0;
      fault_clr_reg <= 1'b0;
      if (bus_start) begin
        state_reg   <= S_ADDR;
        bit_cnt_reg <= 4'h0;
        o_sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= S_IDLE;
        o_sda_oe  <= 1'b0;
      end else begin
        case (state_reg)
          S_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          S_ADDR: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_now};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              if (shift_reg[7:1] == SLAVE_ADDR) begin
                rw_reg    <= shift_reg[0];
                o_sda_oe  <= 1'b1;
                state_reg <= S_AACK;
              end else begin
                state_reg <= S_IDLE;
              end
            end
          end
          S_AACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                shift_reg     <= rd_byte;
                o_sda_oe      <= ~rd_byte[7];  // msb goes out first
                fault_clr_reg <= (ptr_reg == `CCSR_OFS_FAULT);
                ptr_reg       <= ptr_reg + 8'h01;
                bit_cnt_reg   <= 4'h1;
                state_reg     <= S_TX;
              end else begin
                o_sda_oe    <= 1'b0;
                first_reg   <= 1'b1;
                bit_cnt_reg <= 4'h0;
                state_reg   <= S_RX;
              end
            end
          end
          S_RX: begin
            if (scl_rise) begin
              shift_reg   <= {shift_reg[6:0], sda_now};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              o_sda_oe  <= 1'b1;
              state_reg <= S_WACK;
              if (first_reg) begin
                ptr_reg   <= shift_reg;
                first_reg <= 1'b0;
              end else begin
                wr_en_reg   <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg     <= ptr_reg + 8'h01;
              end
            end
          end
          S_WACK: begin
            if (scl_fall) begin
              o_sda_oe    <= 1'b0;
              bit_cnt_reg <= 4'h0;
              state_reg   <= S_RX;
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h8) begin
                o_sda_oe  <= 1'b0;
                state_reg <= S_MACK;
              end else begin
                o_sda_oe    <= ~shift_reg[6];
                shift_reg   <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              nack_reg <= sda_now;
            end else if (scl_fall) begin
              if (nack_reg) begin
                state_reg <= S_IDLE;
              end else begin
                shift_reg     <= rd_byte;
                o_sda_oe      <= ~rd_byte[7];  // msb goes out first
                fault_clr_reg <= (ptr_reg == `CCSR_OFS_FAULT);
                ptr_reg       <= ptr_reg + 8'h01;
                bit_cnt_reg   <= 4'h1;
                state_reg     <= S_TX;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
            o_sda_oe  <= 1'b0;
          end
        endcase
      end
    end
  end

  // command bits of the power-on configuration register act and self-clear
  assign reg_reset_cmd = wr_en_reg & (wr_addr_reg == `CCSR_OFS_POWER_ON_CFG)
                         & wr_data_reg[`CCSR_BIT_REG_RESET];
  assign wdog_kick     = wr_en_reg & (wr_addr_reg == `CCSR_OFS_POWER_ON_CFG)
                         & wr_data_reg[`CCSR_BIT_WDOG_KICK];
  assign ctrl_default  = reg_reset_cmd | wdog_expire;

  // control registers: defaults on reset command or watchdog expiry
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      timer_term_reg <= `CCSR_RST_TIMER_TERM;
      misc_ctrl_reg  <= `CCSR_RST_MISC_CTRL;
    end else if (ctrl_default) begin
      timer_term_reg <= `CCSR_RST_TIMER_TERM;
      misc_ctrl_reg  <= `CCSR_RST_MISC_CTRL;
    end else if (wr_en_reg) begin
      if (wr_addr_reg == `CCSR_OFS_TIMER_TERM)
        timer_term_reg <= wr_data_reg & `CCSR_MSK_TIMER_TERM;
      if (wr_addr_reg == `CCSR_OFS_MISC_CTRL)
        misc_ctrl_reg <= wr_data_reg & `CCSR_MSK_MISC_CTRL;
    end
  end

  // control field outputs
  assign o_term_enable               = timer_term_reg[`CCSR_BIT_TERM_EN];
  assign o_host_watchdog_period      = timer_term_reg[`CCSR_BIT_WDOG_HI:`CCSR_BIT_WDOG_LO];
  assign o_safety_timer_enable       = timer_term_reg[`CCSR_BIT_STMR_EN];
  assign o_safety_timer_duration     = timer_term_reg[`CCSR_BIT_STMR_HI:`CCSR_BIT_STMR_LO];
  assign o_termination_timer_option  = timer_term_reg[`CCSR_BIT_TERMINATION_TIMER_OPTION];
  assign o_battery_switch_off        = misc_ctrl_reg[`CCSR_BIT_BATT_OFF];
  assign o_thermistor_monitor_enable = misc_ctrl_reg[`CCSR_BIT_NTC_EN];
  assign o_junction_temp_limit       = misc_ctrl_reg[`CCSR_BIT_TJ_HI:`CCSR_BIT_TJ_LO];

  // live status register, untouched by reset command and expiry
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sys_state_reg <= `CCSR_RST_SYS_STATE;
    end else begin
      sys_state_reg <= {1'b0, REVISION,
                        stat_s2_reg[8:7],
                        stat_s2_reg[6],
                        stat_s2_reg[5],
                        stat_s2_reg[4]};
    end
  end

  // sticky fault sources; a set in the clearing cycle wins
  assign fault_set = {1'b0, wdog_expire,
                      stat_s2_reg[3],
                      stat_s2_reg[2],
                      stat_s2_reg[1],
                      stat_s2_reg[0],
                      2'h0};

  always @* begin
    fault_next = fault_reg;
    if (fault_clr_reg)
      fault_next = 8'h00;
    fault_next = fault_next | fault_set;
  end

  // fault register, cleared only by power-on or a host read
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      fault_reg <= `CCSR_RST_FAULT;
    end else begin
      fault_reg <= fault_next;
    end
  end

  // registered expiry pulse for the charger logic
  always @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_host_watchdog_expiry <= 1'b0;
    end else begin
      o_host_watchdog_expiry <= wdog_expire;
    end
  end

  // host watchdog, frozen while the input supply is not good
  ccsr_wdog #(
    .SECOND_CYCLES (SECOND_CYCLES)
  ) u_wdog (
    .i_clock  (i_clock),
    .i_arst_n (i_arst_n),
    .i_period (o_host_watchdog_period),
    .i_kick   (wdog_kick),
    .i_freeze (~stat_s2_reg[5]),
    .o_expire (wdog_expire)
  );

endmodule
`default_nettype wire

/* File: testbench/ccsr_regs_monitor.sv */
// Purpose: port-level checks for the charger register bank
// Assumes: one core clock, async active-low reset
// Notes:   bound to ccsr_regs below the module
`timescale 1ns/10ps
`default_nettype none
module ccsr_regs_monitor (
  input wire logic       i_clock,                      // core clock
  input wire logic       i_arst_n,                     // async reset
  input wire logic       i_input_good_flag,            // supply good
  input wire logic       o_term_enable,                // termination on
  input wire logic [1:0] o_host_watchdog_period,       // watchdog code
  input wire logic       o_safety_timer_enable,        // safety timer on
  input wire logic [1:0] o_safety_timer_duration,      // timer code
  input wire logic       o_termination_timer_option,   // term timer
  input wire logic       o_battery_switch_off,         // battery off
  input wire logic       o_thermistor_monitor_enable,  // thermistor on
  input wire logic [1:0] o_junction_temp_limit,        // junction code
  input wire logic       o_host_watchdog_expiry        // expiry pulse
);
  // control outputs packed as their register fields
  wire [6:0] tt = {o_term_enable, o_host_watchdog_period, o_safety_timer_enable,
                   o_safety_timer_duration, o_termination_timer_option};
  wire [3:0] mc = {o_battery_switch_off, o_thermistor_monitor_enable, o_junction_temp_limit};
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  a_reset_tt_default: assert property ($rose(i_arst_n) |-> tt == 7'h4A)
    else $error("timer control not at default after reset");
  a_reset_misc_default: assert property ($rose(i_arst_n) |-> mc == 4'h7)
    else $error("misc control not at default after reset");
  a_expiry_one_cycle: assert property (o_host_watchdog_expiry |=> !o_host_watchdog_expiry)
    else $error("expiry pulse longer than one cycle");
  a_expiry_tt_restore: assert property (o_host_watchdog_expiry |-> ##[0:2] tt == 7'h4A)
    else $error("timer control not restored on expiry");
  a_expiry_misc_restore: assert property (o_host_watchdog_expiry |-> ##[0:2] mc == 4'h7)
    else $error("misc control not restored on expiry");
  a_expiry_needs_period: assert property (
    o_host_watchdog_expiry |-> $past(o_host_watchdog_period, 3) != 2'h0)
    else $error("expiry while watchdog was off");
  a_off_no_expiry: assert property (o_host_watchdog_period == 2'h0 [*4] |=> !o_host_watchdog_expiry)
    else $error("expiry with watchdog off");
  a_frozen_no_expiry: assert property (!i_input_good_flag [*6] |=> !o_host_watchdog_expiry)
    else $error("expiry while supply absent");
endmodule
bind ccsr_regs ccsr_regs_monitor u_mon (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_input_good_flag(i_input_good_flag),
  .o_term_enable(o_term_enable), .o_host_watchdog_period(o_host_watchdog_period),
  .o_safety_timer_enable(o_safety_timer_enable),
  .o_safety_timer_duration(o_safety_timer_duration),
  .o_termination_timer_option(o_termination_timer_option),
  .o_battery_switch_off(o_battery_switch_off),
  .o_thermistor_monitor_enable(o_thermistor_monitor_enable),
  .o_junction_temp_limit(o_junction_temp_limit),
  .o_host_watchdog_expiry(o_host_watchdog_expiry));
`default_nettype wire

/* File: testbench/ccsr_host_model.sv */
// Purpose: host side of the two-wire bus
// Assumes: pulled-up data line, 800 ns bit time
// Notes:   a released line reads the pull-up level
`timescale 1ns/10ps
`default_nettype none
module ccsr_host_model (
  input  wire logic i_sda,      // resolved data line
  output var logic  o_scl,      // serial clock
  output var logic  o_sda_low   // pull data low
);
  // bus idles released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // start or repeated start, waits out a slave acknowledge first
  task automatic start();
    o_sda_low = 1'b0;
    #500 o_scl = 1'b1;
    #300 o_sda_low = 1'b1;
    #300 o_scl = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    #100 o_sda_low = 1'b1;
    #300 o_scl = 1'b1;
    #300 o_sda_low = 1'b0;
  endtask
  // one bit: data moves early in low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    #100 o_sda_low = !b;
    #400 o_scl = 1'b1;
    #150 r = i_sda;
    #150 o_scl = 1'b0;
  endtask
  // byte out msb first, then one tail bit out, returns bits read
  task automatic xfer(input [7:0] v, input logic t, output [7:0] r, output logic a);
    for (int k = 7; k >= 0; k--) begin
      bit_io(v[k], r[k]);
    end
    bit_io(t, a);
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the charger register bank
// Assumes: host model drives the bus, bench drives status levels
// Notes:   one watchdog second is shortened to SEC cycles
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam [1:0]   REV = 2'h1;  // arbitrary revision code
  localparam integer SEC = 20;    // cycles per watchdog second
  logic        i_clock  = 1'b0;
  logic        i_arst_n = 1'b0;
  logic [8:0]  sv       = 9'h000;        // status and fault levels
  logic [31:0] rnd      = 32'h4F287650;  // random state
  integer      errors   = 0;
  integer      n_checks = 0;
  integer      i;
  integer      cnt;
  wire         scl;
  wire         sda_low;
  wire         dut_oe;
  wire         dut_sda;
  wire         exp_pulse;
  wire [6:0]   tt;
  wire [3:0]   mc;
  // open-drain data line with pull-up
  wire         sda = sda_low ? 1'b0 : (dut_oe ? dut_sda : 1'b1);
  always #50 i_clock = ~i_clock;
  ccsr_regs #(.REVISION(REV), .SECOND_CYCLES(SEC)) u_dut (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda), .o_sda(dut_sda),
    .o_sda_oe(dut_oe), .i_charge_state(sv[1:0]), .i_path_limit_flag(sv[2]),
    .i_input_good_flag(sv[3]), .i_thermal_regulation_flag(sv[4]),
    .i_safety_timer_fault_flag(sv[5]), .i_battery_overvoltage_flag(sv[6]),
    .i_thermal_shutdown_flag(sv[7]), .i_input_fault_flag(sv[8]),
    .o_term_enable(tt[6]), .o_host_watchdog_period(tt[5:4]), .o_safety_timer_enable(tt[3]),
    .o_safety_timer_duration(tt[2:1]), .o_termination_timer_option(tt[0]),
    .o_battery_switch_off(mc[3]), .o_thermistor_monitor_enable(mc[2]),
    .o_junction_temp_limit(mc[1:0]), .o_host_watchdog_expiry(exp_pulse));
  ccsr_host_model u_host (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // random source, readback and port expectations
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic [7:0] rb(input [7:0] o, input [7:0] v);
    rb = (o == 8'h05) ? (v & 8'h7F) : (v & 8'h2B);
  endfunction
  function automatic [7:0] pe(input [7:0] o, input [7:0] v);
    pe = (o == 8'h05) ? (v & 8'h7F) : {4'h0, v[5], v[3], v[1:0]};
  endfunction
  function automatic integer wlen(input integer c);
    wlen = (40 * SEC) << (c - 1);
  endfunction
  task automatic chk(input [7:0] g, input [7:0] e);
    n_checks = n_checks + 1;
    if (g !== e) begin
      errors = errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // register write and checked register read over the bus
  task automatic wr(input [7:0] o, input [7:0] v);
    logic [7:0] r;
    logic       a;
    u_host.start();
    u_host.xfer(8'h12, 1'b1, r, a);
    u_host.xfer(o, 1'b1, r, a);
    u_host.xfer(v, 1'b1, r, a);
    u_host.stop();
  endtask
  task automatic rdc(input [7:0] o, input [7:0] e);
    logic [7:0] r;
    logic       a;
    u_host.start();
    u_host.xfer(8'h12, 1'b1, r, a);
    u_host.xfer(o, 1'b1, r, a);
    u_host.start();
    u_host.xfer(8'h13, 1'b1, r, a);
    u_host.xfer(8'hFF, 1'b1, r, a);
    u_host.stop();
    chk(r, e);
  endtask
  task automatic wrc(input [7:0] o, input [7:0] v);
    wr(o, v);
    chk((o == 8'h05) ? {1'b0, tt} : {4'h0, mc}, pe(o, v));
    rdc(o, rb(o, v));
  endtask
  // wait for the expiry pulse, at most lim cycles
  task automatic wait_exp(input integer lim);
    cnt = 0;
    while (exp_pulse !== 1'b1 && cnt < lim) begin
      @(negedge i_clock);
      cnt = cnt + 1;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge i_clock);
    i_arst_n = 1'b1;
    rdc(8'h05, 8'h4A);
    rdc(8'h06, 8'h0B);
    rdc(8'h07, {1'b0, REV, 5'h00});
    rdc(8'h08, 8'h00);
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wrc(i[0] ? 8'h06 : 8'h05, ((i < 2) ? 8'hFF : rnd[7:0]) & (i[0] ? 8'hFF : 8'hCF));
    end
    wr(8'h06, 8'h20);
    wr(8'h01, 8'h00);
    rdc(8'h06, 8'h20);
    wr(8'h01, 8'h80);
    rdc(8'h05, 8'h4A);
    rdc(8'h06, 8'h0B);
    $display("control test done");
    for (i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      @(negedge i_clock) sv = {4'h0, rnd[4:2], i[1:0]};
      wr(8'h07, rnd[15:8]);
      rdc(8'h07, {1'b0, REV, sv[1:0], sv[2], sv[3], sv[4]});
    end
    $display("status test done");
    for (i = 0; i < 4; i++) begin
      @(negedge i_clock) sv[5 + i] = 1'b1;
      repeat (5) @(negedge i_clock);
      sv[5 + i] = 1'b0;
      wr(8'h01, 8'h80);
      rdc(8'h08, 8'h04 << i);
      rdc(8'h08, 8'h00);
    end
    $display("fault test done");
    @(negedge i_clock) sv = 9'h008;
    for (i = 1; i < 4; i++) begin
      wr(8'h01, 8'h40);
      wr(8'h05, 8'h4A | (i[7:0] << 4));
      wait_exp(4000);
      chk({7'h00, cnt > wlen(i) - 30 && cnt <= wlen(i)}, 8'h01);
      rdc(8'h05, 8'h4A);
      rdc(8'h08, 8'h40);
    end
    wr(8'h01, 8'h40);
    wr(8'h05, 8'h5A);
    @(negedge i_clock) sv[3] = 1'b0;
    wait_exp(1500);
    chk({7'h00, cnt == 1500}, 8'h01);
    sv[3] = 1'b1;
    wait_exp(1000);
    chk({7'h00, cnt < 1000}, 8'h01);
    $display("watchdog test done");
    finish_test();
  end
  // hang guard
  initial begin
    #6000000;
    errors = errors + 1;
    finish_test();
  end
endmodule
`default_nettype wire
